// *** logic/srf_reply_formatter.sv ***
// Module: sensor reply formatter, builds ASCII replies into a FIFO
//
// Overview of operation
// - Errors are held as bits of one 16-bit word sent as four hex chars.
// - Bits 0..3 flag no compensation, temp index overflow/range, press idx.
// - Bits 5..7 flag linear stage, scaling and high-res overflows; 4 unused.
// - Bit 8 flags out-of-range pressure, clamped to the nearer limit.
// - Bits 9 to 15 are reserved and carry no meaning.
// - Bits 1 to 3 and 5 to 7 only flag arithmetic faults of the compensation math.
// - A calibrated part never reports bit 0; the host may read it so.
// - A mismatched serial number on an addressed command sends nothing.
// - The serial number is twelve chars: YMDD-NN-BSPP.
// - Year digit, month A..M without I, batch A..Z, slot 1..5, pos 1..15.
// - Pressure range: low, sp, to, sp, high, sp, unit, mode letter A/D/G.
// - Temperature range: low, sp, to, sp, high, sp, C.
// - Pressure reply: command, =, four hex value, sp, four hex error, CR.
// - Any error other than the limit flag forces the value to 8000.
// - Every reply ends in a carriage return.
`timescale 1ns/100ps
module srf_reply_formatter #(
  parameter int DEPTH = srf_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Request from the command parser
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [1:0]  req_kind,
  input  wire logic [15:0] req_cmd,
  input  wire logic        req_addressed,
  input  wire logic [95:0] req_sn,
  // Pressure result and compensation fault flags
  input  wire logic [15:0] press_value,
  input  wire logic        press_above,
  input  wire logic        press_below,
  input  wire logic [15:0] press_hi_limit,
  input  wire logic [15:0] press_lo_limit,
  input  wire logic        fault_uncal,
  input  wire logic        fault_tidx_ovf,
  input  wire logic        fault_tidx_rng,
  input  wire logic        fault_pidx_rng,
  input  wire logic        fault_pwl_ovf,
  input  wire logic        fault_scale_ovf,
  input  wire logic        fault_hres_ovf,
  // Identity of this part
  input  wire logic [3:0]  sn_year,
  input  wire logic [3:0]  sn_month,
  input  wire logic [4:0]  sn_day,
  input  wire logic [6:0]  sn_lot,
  input  wire logic [4:0]  sn_batch,
  input  wire logic [2:0]  sn_slot,
  input  wire logic [3:0]  sn_pos,
  input  wire logic [31:0] prange_lo_txt,
  input  wire logic [31:0] prange_hi_txt,
  input  wire logic [31:0] prange_unit_txt,
  input  wire logic [1:0]  prange_mode,
  input  wire logic [31:0] trange_lo_txt,
  input  wire logic [31:0] trange_hi_txt,
  // Status
  output logic             busy,
  output logic             dropped,
  output logic [15:0]      err_word,
  // Character output to the serial transmitter
  output logic [7:0]       tx_data,
  output logic             tx_valid,
  input  wire logic        tx_ready
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Longest reply: head, two full limits, " to ", sp, full unit, mode, CR
  localparam int MAXLEN = 22;

  function automatic logic [7:0] dec_char(input logic [3:0] d);
    return srf_pkg::CH_0 + {4'h0, d};
  endfunction : dec_char

  function automatic logic [15:0] two_dig(input logic [6:0] v);
    logic [6:0] t;
    logic [6:0] o;
    t = v / 7'd10;
    o = v - t * 7'd10;
    return {dec_char(t[3:0]), dec_char(o[3:0])};
  endfunction : two_dig

  // Month 1..12 maps to A..M skipping I
  function automatic logic [7:0] month_char(input logic [3:0] m);
    if (m >= 4'd9) begin
      return srf_pkg::CH_UA + {4'h0, m};
    end
    return srf_pkg::CH_UA + {4'h0, m} - 8'h01;
  endfunction : month_char

  // Text fields are four characters, a zero byte marks an unused slot
  function automatic logic [7:0] field_char(input logic [31:0] f,
                                            input int idx);
    return f[8*(3-idx) +: 8];
  endfunction : field_char

  // ----------------------------------------------------------------------
  // Error word and pressure value
  // ----------------------------------------------------------------------
  logic [15:0] err_now;
  logic [15:0] val_now;
  logic [31:0] val_hex;
  logic [31:0] err_hex;

  always_comb begin
    err_now = '0;
    err_now[srf_pkg::ERR_UNCAL]     = fault_uncal;
    err_now[srf_pkg::ERR_TIDX_OVF]  = fault_tidx_ovf;
    err_now[srf_pkg::ERR_TIDX_RNG]  = fault_tidx_rng;
    err_now[srf_pkg::ERR_PIDX_RNG]  = fault_pidx_rng;
    err_now[srf_pkg::ERR_PWL_OVF]   = fault_pwl_ovf;
    err_now[srf_pkg::ERR_SCALE_OVF] = fault_scale_ovf;
    err_now[srf_pkg::ERR_HRES_OVF]  = fault_hres_ovf;
    err_now[srf_pkg::ERR_LIMITED]   = press_above | press_below;
    err_now = err_now & ~srf_pkg::ERR_RESERVED_MASK;
  end

  // Bits 1..3 and 5..7 come only from the compensation fault inputs, bit 0 from
  // the calibration state; the host reads bit 0 as an uncalibrated part.
  always_comb begin
    if ((err_now & srf_pkg::ERR_FORCE_MASK) != 16'h0000) begin
      val_now = srf_pkg::VALUE_ON_ERROR;
    end else if (press_above) begin
      val_now = press_hi_limit;
    end else if (press_below) begin
      val_now = press_lo_limit;
    end else begin
      val_now = press_value;
    end
  end

  srf_hex_enc u_val_hex (
    .word  (val_now),
    .chars (val_hex)
  );

  srf_hex_enc u_err_hex (
    .word  (err_now),
    .chars (err_hex)
  );

  // ----------------------------------------------------------------------
  // Serial number text and match
  // ----------------------------------------------------------------------
  logic [95:0] sn_txt;
  logic        sn_match;

  always_comb begin
    sn_txt = {dec_char(sn_year), month_char(sn_month),
              two_dig({2'b00, sn_day}), srf_pkg::CH_DASH,
              two_dig(sn_lot), srf_pkg::CH_DASH,
              srf_pkg::CH_UA + {3'b000, sn_batch},
              dec_char({1'b0, sn_slot}),
              two_dig({3'b000, sn_pos})};
  end

  assign sn_match = (req_sn == sn_txt);

  // ----------------------------------------------------------------------
  // Reply line buffer
  // ----------------------------------------------------------------------
  logic [7:0] line [MAXLEN];
  logic [4:0] len_now;
  logic [7:0] line_now [MAXLEN];
  logic [7:0] mode_ch;

  always_comb begin
    case (prange_mode)
      srf_pkg::MODE_DIFF: mode_ch = srf_pkg::CH_D;
      srf_pkg::MODE_GAGE: mode_ch = srf_pkg::CH_G;
      default:            mode_ch = srf_pkg::CH_UA;
    endcase
  end

  // Fixed-width text fields pack out their zero bytes before sending
  always_comb begin
    int n;
    n = 0;
    for (int i = 0; i < MAXLEN; i++) begin
      line_now[i] = srf_pkg::CH_CR;
    end
    line_now[0] = req_cmd[15:8];
    line_now[1] = req_cmd[7:0];
    line_now[2] = srf_pkg::CH_EQ;
    n = 3;
    case (req_kind)
      srf_pkg::REP_PRESSURE: begin
        for (int i = 0; i < 4; i++) begin
          line_now[3+i] = val_hex[8*(3-i) +: 8];
          line_now[8+i] = err_hex[8*(3-i) +: 8];
        end
        line_now[7] = srf_pkg::CH_SP;
        n = 12;
      end
      srf_pkg::REP_SERIAL: begin
        for (int i = 0; i < srf_pkg::SN_LEN; i++) begin
          line_now[3+i] = sn_txt[8*(11-i) +: 8];
        end
        n = 15;
      end
      default: begin
        for (int i = 0; i < srf_pkg::LIM_LEN; i++) begin
          if (field_char(req_kind == srf_pkg::REP_PRANGE ?
                prange_lo_txt : trange_lo_txt, i) != 8'h00) begin
            line_now[n] = field_char(req_kind == srf_pkg::REP_PRANGE ?
                            prange_lo_txt : trange_lo_txt, i);
            n = n + 1;
          end
        end
        line_now[n]   = srf_pkg::CH_SP;
        line_now[n+1] = srf_pkg::CH_LT;
        line_now[n+2] = srf_pkg::CH_LO;
        line_now[n+3] = srf_pkg::CH_SP;
        n = n + 4;
        for (int i = 0; i < srf_pkg::LIM_LEN; i++) begin
          if (field_char(req_kind == srf_pkg::REP_PRANGE ?
                prange_hi_txt : trange_hi_txt, i) != 8'h00) begin
            line_now[n] = field_char(req_kind == srf_pkg::REP_PRANGE ?
                            prange_hi_txt : trange_hi_txt, i);
            n = n + 1;
          end
        end
        line_now[n] = srf_pkg::CH_SP;
        n = n + 1;
        if (req_kind == srf_pkg::REP_PRANGE) begin
          for (int i = 0; i < srf_pkg::UNIT_LEN; i++) begin
            if (field_char(prange_unit_txt, i) != 8'h00) begin
              line_now[n] = field_char(prange_unit_txt, i);
              n = n + 1;
            end
          end
          line_now[n] = mode_ch;
        end else begin
          line_now[n] = srf_pkg::CH_C;
        end
        n = n + 1;
      end
    endcase
    line_now[n] = srf_pkg::CH_CR;
    len_now = 5'(n + 1);
  end

  // ----------------------------------------------------------------------
  // Send sequencer
  // ----------------------------------------------------------------------
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SEND = 1'b1
  } srf_state_e;

  srf_state_e state_reg;
  logic [4:0] idx_reg;
  logic [4:0] len_reg;
  logic       take;
  logic       wr_fire;

  srf_stream_if #(.W(8)) fifo_in ();

  assign req_ready = (state_reg == ST_IDLE);
  assign busy      = (state_reg == ST_SEND);
  assign take      = req_valid && req_ready;
  assign fifo_in.valid = (state_reg == ST_SEND);
  assign fifo_in.data  = line[idx_reg];
  assign wr_fire   = fifo_in.valid && fifo_in.ready;

  always_ff @(posedge clk) begin
    if (take) begin
      line <= line_now;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      idx_reg   <= '0;
      len_reg   <= '0;
      dropped   <= 1'b0;
    end else begin
      dropped <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (take) begin
            if (req_addressed && !sn_match) begin
              dropped <= 1'b1;
            end else begin
              state_reg <= ST_SEND;
              idx_reg   <= '0;
              len_reg   <= len_now;
            end
          end
        end
        ST_SEND: begin
          if (wr_fire) begin
            if (idx_reg == len_reg - 5'd1) begin
              state_reg <= ST_IDLE;
            end else begin
              idx_reg <= idx_reg + 5'd1;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      err_word <= '0;
    end else begin
      err_word <= err_now;
    end
  end

  // ----------------------------------------------------------------------
  // Output FIFO
  // ----------------------------------------------------------------------
  srf_fifo #(
    .WIDTH (8),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .wr        (fifo_in),
    .out_data  (tx_data),
    .out_valid (tx_valid),
    .out_ready (tx_ready)
  );

endmodule : srf_reply_formatter

// *** include/srf_pkg.sv ***
// Package: constants and types shared by the reply formatter
package srf_pkg;

  // ----------------------------------------------------------------------
  // Error word bit positions
  // ----------------------------------------------------------------------
  localparam int ERR_UNCAL     = 0;
  localparam int ERR_TIDX_OVF  = 1;
  localparam int ERR_TIDX_RNG  = 2;
  localparam int ERR_PIDX_RNG  = 3;
  localparam int ERR_PWL_OVF   = 5;
  localparam int ERR_SCALE_OVF = 6;
  localparam int ERR_HRES_OVF  = 7;
  localparam int ERR_LIMITED   = 8;
  localparam logic [15:0] ERR_RESERVED_MASK = 16'hfe10;
  localparam logic [15:0] ERR_FORCE_MASK    = 16'h00ff;

  // ----------------------------------------------------------------------
  // Reply constants
  // ----------------------------------------------------------------------
  localparam logic [15:0] VALUE_ON_ERROR = 16'h8000;
  localparam logic [7:0]  CH_CR    = 8'h0d;
  localparam logic [7:0]  CH_SP    = 8'h20;
  localparam logic [7:0]  CH_EQ    = 8'h3d;
  localparam logic [7:0]  CH_DASH  = 8'h2d;
  localparam logic [7:0]  CH_0     = 8'h30;
  localparam logic [7:0]  CH_1     = 8'h31;
  localparam logic [7:0]  CH_UA    = 8'h41;
  localparam logic [7:0]  CH_C     = 8'h43;
  localparam logic [7:0]  CH_D     = 8'h44;
  localparam logic [7:0]  CH_G     = 8'h47;
  localparam logic [7:0]  CH_T     = 8'h54;
  localparam logic [7:0]  CH_LT    = 8'h74;
  localparam logic [7:0]  CH_LO    = 8'h6f;
  localparam logic [7:0]  CH_R     = 8'h52;
  localparam int          SN_LEN   = 12;
  localparam int          LIM_LEN  = 4;
  localparam int          UNIT_LEN = 4;
  localparam int          FIFO_DEPTH = 16;

  // ----------------------------------------------------------------------
  // Reply kinds and pressure mode
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    REP_PRESSURE = 2'b00,
    REP_SERIAL   = 2'b01,
    REP_PRANGE   = 2'b10,
    REP_TRANGE   = 2'b11
  } srf_kind_e;

  typedef enum logic [1:0] {
    MODE_ABS  = 2'b00,
    MODE_DIFF = 2'b01,
    MODE_GAGE = 2'b10
  } srf_mode_e;

endpackage : srf_pkg

// *** include/srf_stream_if.sv ***
// Interface: byte stream between formatter and output FIFO
`timescale 1ns/100ps
interface srf_stream_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : srf_stream_if

// *** logic/srf_fifo.sv ***
// Module: synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module srf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = srf_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Fill side
  srf_stream_if.snk             wr,
  // Drain side
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("srf_fifo: DEPTH must be a power of two of at least 2");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_reg;
  logic [AW:0]      rp_reg;
  logic             push;
  logic             pop;

  assign wr.ready  = (wp_reg - rp_reg) != (AW+1)'(DEPTH);
  assign out_valid = wp_reg != rp_reg;
  assign push      = wr.valid && wr.ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rp_reg[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_reg[AW-1:0]] <= wr.data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      if (push) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (pop) begin
        rp_reg <= rp_reg + 1'b1;
      end
    end
  end
endmodule : srf_fifo

// *** logic/srf_hex_enc.sv ***
// Module: one 16-bit word to four upper-case ASCII hex characters
`timescale 1ns/100ps
module srf_hex_enc (
  // Word in
  input  wire logic [15:0] word,
  // Characters out, most significant first
  output logic      [31:0] chars
);
  function automatic logic [7:0] hex_char(input logic [3:0] n);
    if (n < 4'ha) begin
      return 8'h30 + {4'h0, n};
    end
    return 8'h37 + {4'h0, n};
  endfunction : hex_char

  for (genvar i = 0; i < 4; i++) begin : g_nib
    assign chars[8*i +: 8] = hex_char(word[4*i +: 4]);
  end
endmodule : srf_hex_enc

// *** verification/srf_host_model.sv ***
// Host side model: takes reply characters off the transmit stream
`timescale 1ns/100ps
module srf_host_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Character stream from the formatter
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  // Stall control from the bench
  input  wire logic       slow
);
  logic [7:0] rx_q[$];
  int         phase;

  initial begin
    tx_ready = 1'b0;
    phase = 0;
  end

  // A slow host accepts only one cycle in four, so the FIFO backs up
  always @(negedge clk) begin
    phase = phase + 1;
    tx_ready <= rst_n && (!slow || phase % 4 == 0);
  end

  // Every character accepted from the stream is pushed onto the receive queue
  always @(posedge clk) begin
    if (rst_n && tx_valid && tx_ready) begin
      rx_q.push_back(tx_data);
    end
  end
endmodule : srf_host_model

// *** verification/srf_reply_formatter_asserts.sv ***
// Checker: port-level properties of the reply formatter
`timescale 1ns/100ps
module srf_asserts (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic        req_addressed,
  input wire logic        press_above,
  input wire logic        press_below,
  input wire logic        fault_uncal,
  input wire logic        fault_tidx_ovf,
  input wire logic        fault_tidx_rng,
  input wire logic        fault_pidx_rng,
  input wire logic        fault_pwl_ovf,
  input wire logic        fault_scale_ovf,
  input wire logic        fault_hres_ovf,
  input wire logic        busy,
  input wire logic        dropped,
  input wire logic [15:0] err_word,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_valid,
  input wire logic        tx_ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_err_reserved_zero: assert property (
    (err_word & srf_pkg::ERR_RESERVED_MASK) == 16'h0000)
    else $error("reserved error bits set");
  a_err_low_bits: assert property (
    $past(rst_n) |-> err_word[3:0] == $past({fault_pidx_rng,
      fault_tidx_rng, fault_tidx_ovf, fault_uncal}))
    else $error("error bits 0 to 3 do not follow the faults");
  a_err_math_bits: assert property (
    $past(rst_n) |-> err_word[7:5] == $past({fault_hres_ovf,
      fault_scale_ovf, fault_pwl_ovf}))
    else $error("error bits 5 to 7 do not follow the faults");
  a_err_limit_bit: assert property (
    $past(rst_n) |-> err_word[8] == $past(press_above || press_below))
    else $error("limit bit does not follow the range flags");
  a_take_starts_reply: assert property (
    req_valid && req_ready && !req_addressed |=> busy && !req_ready)
    else $error("accepted request did not start a reply");
  a_drop_has_cause: assert property (
    dropped |-> $past(req_valid && req_ready && req_addressed))
    else $error("drop without an addressed request");
  a_drop_stays_quiet: assert property (
    dropped |-> !busy ##1 (!busy && !dropped))
    else $error("mismatched request produced output");
  a_tx_held_stall: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("character changed while host stalled");
  a_busy_bounded: assert property (
    $rose(busy) |-> ##[1:300] !busy)
    else $error("reply loading did not finish");
endmodule : srf_asserts

bind srf_reply_formatter srf_asserts u_srf_asserts (
  .clk, .rst_n, .req_valid, .req_ready, .req_addressed, .press_above,
  .press_below, .fault_uncal, .fault_tidx_ovf, .fault_tidx_rng,
  .fault_pidx_rng, .fault_pwl_ovf, .fault_scale_ovf, .fault_hres_ovf,
  .busy, .dropped, .err_word, .tx_data, .tx_valid, .tx_ready);

// *** verification/sensor_reply_formatter_tb.sv ***
// Testbench: reply formatter against a host model
`timescale 1ns/100ps
module sensor_reply_formatter_tb;
  logic clk = 1'b0, rst_n = 1'b0, slow = 1'b0;
  logic req_valid = 1'b0, req_addressed = 1'b0, req_ready, busy, dropped;
  logic [1:0] req_kind = 2'h0, prange_mode = 2'h0;
  logic [15:0] req_cmd = 16'h0000, press_value = 16'h1e43, err_word;
  logic [95:0] req_sn = 96'h0;
  logic press_above = 1'b0, press_below = 1'b0;
  logic [15:0] press_hi_limit = 16'h3f7c, press_lo_limit = 16'h0012;
  logic [6:0] flt = 7'h00;
  logic [3:0] sn_year = 4'h3, sn_month = 4'h4, sn_pos = 4'h3;
  logic [4:0] sn_day = 5'h17, sn_batch = 5'h00;
  logic [6:0] sn_lot = 7'h03;
  logic [2:0] sn_slot = 3'h1;
  logic [31:0] prange_lo_txt = 32'h00003230, prange_hi_txt = 32'h00003332;
  logic [31:0] prange_unit_txt = 32'h6d6d4867;
  logic [31:0] trange_lo_txt = 32'h002d3230, trange_hi_txt = 32'h00003835;
  logic [7:0] tx_data;
  logic tx_valid, tx_ready;
  int fails = 0, tests_run = 0;
  localparam logic [95:0] OWN_SN = 96'h3344_3233_2d30_332d_4131_3033;

  always #25 clk = ~clk;

  srf_reply_formatter dut (.clk, .rst_n, .req_valid, .req_ready, .req_kind,
    .req_cmd, .req_addressed, .req_sn, .press_value, .press_above,
    .press_below, .press_hi_limit, .press_lo_limit, .fault_uncal(flt[0]),
    .fault_tidx_ovf(flt[1]), .fault_tidx_rng(flt[2]), .fault_pidx_rng(flt[3]),
    .fault_pwl_ovf(flt[4]), .fault_scale_ovf(flt[5]), .fault_hres_ovf(flt[6]),
    .sn_year, .sn_month, .sn_day, .sn_lot, .sn_batch, .sn_slot, .sn_pos,
    .prange_lo_txt, .prange_hi_txt, .prange_unit_txt, .prange_mode,
    .trange_lo_txt, .trange_hi_txt, .busy, .dropped, .err_word, .tx_data,
    .tx_valid, .tx_ready);
  srf_host_model host (.clk, .rst_n, .tx_data, .tx_valid, .tx_ready, .slow);

  // --------------------------------------------------------------------
  // Shared helpers
  // --------------------------------------------------------------------
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask : chk

  function automatic string hex4(logic [15:0] v);
    string s;
    s = "";
    for (int i = 3; i >= 0; i--) begin
      s = {s, string'(v[i*4 +: 4] < 10 ? 8'h30 + v[i*4 +: 4]
                                        : 8'h37 + v[i*4 +: 4])};
    end
    return s;
  endfunction : hex4

  task automatic request(logic [1:0] k, logic [15:0] c, logic a,
                         logic [95:0] sn);
    int n;
    @(negedge clk);
    req_kind = k;
    req_cmd = c;
    req_addressed = a;
    req_sn = sn;
    req_valid = 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 400);
    if (req_ready !== 1'b1) begin
      $display("wrong value req_ready expected 1 seen %b", req_ready);
      fails++;
    end
    @(negedge clk);
    req_valid = 1'b0;
  endtask : request

  task automatic expect_reply(string exp);
    int n;
    n = 0;
    while (host.rx_q.size() < exp.len() && n < 600) begin
      @(negedge clk);
      n++;
    end
    chk("reply length", 16'(exp.len()), 16'(host.rx_q.size()));
    for (int i = 0; i < exp.len() && i < host.rx_q.size(); i++) begin
      chk("reply char", {8'h00, exp[i]}, {8'h00, host.rx_q[i]});
    end
    host.rx_q.delete();
    repeat (4) @(negedge clk);
    chk("busy after reply", 16'h0000, {15'h0, busy});
  endtask : expect_reply

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_plain;
    request(2'h0, 16'h5248, 1'b0, 96'h0);
    expect_reply("RH=1E43 0000\r");
  endtask : t_plain

  task automatic t_limits;
    press_above = 1'b1;
    request(2'h0, 16'h5248, 1'b0, 96'h0);
    expect_reply({"RH=", hex4(press_hi_limit), " 0100\r"});
    press_above = 1'b0;
    press_below = 1'b1;
    request(2'h0, 16'h5248, 1'b0, 96'h0);
    expect_reply({"RH=", hex4(press_lo_limit), " 0100\r"});
    flt = 7'h40;
    request(2'h0, 16'h5248, 1'b0, 96'h0);
    expect_reply("RH=8000 0180\r");
    flt = 7'h00;
    press_below = 1'b0;
  endtask : t_limits

  task automatic t_faults;
    int b;
    for (int i = 0; i < 7; i++) begin
      b = (i < 4) ? i : i + 1;
      @(negedge clk);
      flt = 7'h01 << i;
      @(negedge clk);
      chk("error word", 16'h0001 << b, err_word);
      request(2'h0, 16'h5248, 1'b0, 96'h0);
      expect_reply({"RH=8000 ", hex4(16'h0001 << b), "\r"});
    end
    flt = 7'h00;
  endtask : t_faults

  task automatic t_serial;
    request(2'h1, 16'h5253, 1'b0, 96'h0);
    expect_reply("RS=3D23-03-A103\r");
    sn_month = 4'hc;
    sn_batch = 5'h19;
    sn_slot = 3'h5;
    sn_pos = 4'hf;
    request(2'h1, 16'h5253, 1'b0, 96'h0);
    expect_reply("RS=3M23-03-Z515\r");
    sn_month = 4'h9;
    request(2'h1, 16'h5253, 1'b0, 96'h0);
    expect_reply("RS=3J23-03-Z515\r");
    {sn_month, sn_batch, sn_slot, sn_pos} = {4'h4, 5'h00, 3'h1, 4'h3};
  endtask : t_serial

  task automatic t_ranges;
    string m;
    m = "ADGA";
    slow = 1'b1;
    for (int i = 0; i < 4; i++) begin
      prange_mode = 2'(i);
      request(2'h2, 16'h5252, 1'b0, 96'h0);
      expect_reply({"RR=20 to 32 mmHg", string'(m[i]), "\r"});
    end
    slow = 1'b0;
    request(2'h3, 16'h5254, 1'b0, 96'h0);
    expect_reply("RT=-20 to 85 C\r");
  endtask : t_ranges

  task automatic t_address;
    request(2'h0, 16'h5248, 1'b1, OWN_SN ^ 96'h7);
    chk("dropped pulse", 16'h0001, {15'h0, dropped});
    repeat (20) @(negedge clk);
    chk("silent line", 16'h0000, 16'(host.rx_q.size()));
    request(2'h0, 16'h5248, 1'b1, OWN_SN);
    expect_reply("RH=1E43 0000\r");
  endtask : t_address

  // --------------------------------------------------------------------
  // Run control
  // --------------------------------------------------------------------
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    t_plain();
    t_limits();
    t_faults();
    t_serial();
    t_ranges();
    t_address();
    print_verdict();
  end

  initial begin
    #(50 * 20000);
    fails++;
    print_verdict();
  end
endmodule : sensor_reply_formatter_tb
